// ===== common/cwgsd_pkg.sv
// Package: register map, field positions, reset values and types of the waveform generator
package cwgsd_pkg;
   // Register byte addresses
   localparam logic [7:0] CWGSD_ADDR_MAIN     = 8'h00;
   localparam logic [7:0] CWGSD_ADDR_OVR_SRC  = 8'h04;
   localparam logic [7:0] CWGSD_ADDR_SHDN     = 8'h08;
   localparam logic [7:0] CWGSD_ADDR_DB_RISE  = 8'h0C;
   localparam logic [7:0] CWGSD_ADDR_DB_FALL  = 8'h10;
   // Field positions
   localparam int CWGSD_BIT_EN      = 7;
   localparam int CWGSD_BIT_OEB     = 6;
   localparam int CWGSD_BIT_OEA     = 5;
   localparam int CWGSD_BIT_POLB    = 4;
   localparam int CWGSD_BIT_POLA    = 3;
   localparam int CWGSD_BIT_CS      = 0;
   localparam int CWGSD_BIT_LVLB_HI = 7;
   localparam int CWGSD_BIT_LVLB_LO = 6;
   localparam int CWGSD_BIT_LVLA_HI = 5;
   localparam int CWGSD_BIT_LVLA_LO = 4;
   localparam int CWGSD_BIT_IS_HI   = 2;
   localparam int CWGSD_BIT_ASE     = 7;
   localparam int CWGSD_BIT_ARSEN   = 6;
   localparam int CWGSD_BIT_SDC1    = 2;
   localparam int CWGSD_BIT_SDFLT   = 1;
   // Writable masks (unimplemented bits read zero)
   localparam logic [7:0] CWGSD_MASK_MAIN    = 8'hF9;
   localparam logic [7:0] CWGSD_MASK_OVR_SRC = 8'hF7;
   localparam logic [7:0] CWGSD_MASK_SHDN    = 8'hC6;
   localparam logic [7:0] CWGSD_MASK_DB      = 8'h3F;
   // Reset values
   localparam logic [7:0] CWGSD_RST_REG = 8'h00;
   // Override level codes
   localparam logic [1:0] CWGSD_LVL_INACT = 2'h0;
   localparam logic [1:0] CWGSD_LVL_FLOAT = 2'h1;
   localparam logic [1:0] CWGSD_LVL_LOW   = 2'h2;
   localparam logic [1:0] CWGSD_LVL_HIGH  = 2'h3;
   // Input source codes
   localparam logic [2:0] CWGSD_SRC_CMP  = 3'h0;
   localparam logic [2:0] CWGSD_SRC_PWM1 = 3'h2;
   localparam logic [2:0] CWGSD_SRC_PWM2 = 3'h3;
   localparam logic [2:0] CWGSD_SRC_PWM3 = 3'h4;
   // Internal oscillator enable divider: 100 MHz / 16 MHz, rounded down
   localparam int CWGSD_SYS_MHZ = 100;
   localparam int CWGSD_OSC_MHZ = 16;
   localparam logic [2:0] CWGSD_OSC_DIV = 3'(CWGSD_SYS_MHZ / CWGSD_OSC_MHZ);
   // AXI4-Lite responses
   localparam logic [1:0] CWGSD_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CWGSD_RESP_SLVERR = 2'h2;

   // Dead-band sequencer states
   typedef enum logic [3:0] {
      CWGSD_ST_SHUT  = 4'b0001,
      CWGSD_ST_RDB   = 4'b0010,
      CWGSD_ST_AON   = 4'b0100,
      CWGSD_ST_FDB   = 4'b1000
   } cwgsd_state_t;

   // Register bus request channels, write and read
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } cwgsd_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cwgsd_axi_rsp_t;

   // Pin pair A and B: output value and active-low enable for each
   typedef struct packed {
      logic a_out;
      logic a_oe_n;
      logic b_out;
      logic b_oe_n;
   } cwgsd_pins_t;
endpackage

// ===== hdl/cwgsd_top.sv
// Complementary waveform generator with dead band, auto-shutdown and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module cwgsd_top
   import cwgsd_pkg::*;
#(
   parameter int DB_W = 6
) (
   // Clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // AXI4-Lite slave
   input  wire cwgsd_pkg::cwgsd_axi_req_t axi_req,
   output      cwgsd_pkg::cwgsd_axi_rsp_t axi_rsp,
   // Waveform sources and shutdown inputs
   input  wire logic                      comparator_out_unsynced,
   input  wire logic                      pwm_channel1_out,
   input  wire logic                      pwm_channel2_out,
   input  wire logic                      pwm_channel3_out,
   input  wire logic                      fault_input_n,
   // Output pins
   output      cwgsd_pkg::cwgsd_pins_t    pins
);
   import cwgsd_pkg::*;

   typedef struct packed {
      cwgsd_axi_rsp_t  rsp;
      logic            aw_held;
      logic [7:0]      aw_addr;
      logic            w_held;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic [7:0]      main_r;
      logic [7:0]      ovr_r;
      logic [7:0]      shdn_r;
      logic [7:0]      dbr_r;
      logic [7:0]      dbf_r;
      logic [4:0]      s1;
      logic [4:0]      s2;
      logic            src_d;
      logic [2:0]      div;
      cwgsd_state_t    st;
      logic [DB_W:0]   cnt;
      logic            a_raw;
      logic            b_raw;
      cwgsd_pins_t     pins;
   } cwgsd_regs_t;

   cwgsd_regs_t state_reg;
   cwgsd_regs_t state_next;

   function automatic logic [7:0] cwgsd_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask, input logic lane);
      cwgsd_merge = lane ? (new_v & mask) : old_v;
   endfunction

   // Output pin value from override code, polarity and running level
   function automatic logic [1:0] cwgsd_pin(input logic shut, input logic [1:0] code,
                                           input logic inv, input logic run, input logic oe);
      logic v;
      logic drv;
      v = run ^ inv;
      drv = oe;
      if (shut) begin
         unique case (code)
            CWGSD_LVL_HIGH:  v = 1'b1;
            CWGSD_LVL_LOW:   v = 1'b0;
            CWGSD_LVL_FLOAT: drv = 1'b0;
            default:         v = run ^ inv;
         endcase
      end
      cwgsd_pin = {v, ~drv};
   endfunction

   logic           en;
   logic           osc_sel;
   logic [2:0]     src_sel;
   logic           cmp_s;
   logic           flt_s;
   logic           src_s;
   logic           src_valid;
   logic           tick;
   logic           rise;
   logic           fall;
   logic           sd_active;
   logic           wr_fire;
   logic [7:0]     wb;
   logic           lane0;
   logic           clr_ok;
   logic           sw_sd;
   logic [1:0]     pa;
   logic [1:0]     pb;

   assign en      = state_reg.main_r[CWGSD_BIT_EN];
   assign osc_sel = state_reg.main_r[CWGSD_BIT_CS];
   assign src_sel = state_reg.ovr_r[CWGSD_BIT_IS_HI:0];
   // Second stage only; first stage is never read elsewhere
   assign cmp_s   = state_reg.s2[0];
   assign flt_s   = ~state_reg.s2[4];

   always_comb begin
      state_next = state_reg;
      src_s = 1'b0;
      src_valid = 1'b1;
      sw_sd = 1'b0;
      unique case (src_sel)
         CWGSD_SRC_CMP:  src_s = state_reg.s2[0];
         CWGSD_SRC_PWM1: src_s = state_reg.s2[1];
         CWGSD_SRC_PWM2: src_s = state_reg.s2[2];
         CWGSD_SRC_PWM3: src_s = state_reg.s2[3];
         default:        src_valid = 1'b0;
      endcase

      state_next.s1 = {~fault_input_n, pwm_channel3_out, pwm_channel2_out,
                       pwm_channel1_out, comparator_out_unsynced};
      state_next.s2 = state_reg.s1;

      // internal oscillator rate as an enable pulse
      tick = 1'b1;
      if (osc_sel) begin
         tick = (state_reg.div == 3'h0);
         state_next.div = tick ? CWGSD_OSC_DIV - 3'h1 : state_reg.div - 3'h1;
      end
      if (tick) begin
         state_next.src_d = src_s & src_valid;
      end
      rise = tick & src_s & src_valid & ~state_reg.src_d;
      fall = tick & ~(src_s & src_valid) & state_reg.src_d;

      // comparator shutdown; fault pin shutdown; level sensitive
      sd_active = (state_reg.shdn_r[CWGSD_BIT_SDC1] & cmp_s)
                | (state_reg.shdn_r[CWGSD_BIT_SDFLT] & ~flt_s);
      clr_ok = ~sd_active;

      // AXI4-Lite write: address and data taken in either order
      state_next.rsp.awready = ~state_reg.aw_held & ~state_reg.rsp.bvalid;
      state_next.rsp.wready  = ~state_reg.w_held & ~state_reg.rsp.bvalid;
      if (axi_req.awvalid && axi_rsp.awready) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = axi_req.awaddr;
         state_next.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         state_next.w_held = 1'b1;
         state_next.w_data = axi_req.wdata;
         state_next.w_strb = axi_req.wstrb;
         state_next.rsp.wready = 1'b0;
      end
      wr_fire = state_reg.aw_held & state_reg.w_held & ~state_reg.rsp.bvalid;
      wb = state_reg.w_data[7:0];
      lane0 = state_reg.w_strb[0];
      if (wr_fire) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.rsp.bvalid = 1'b1;
         state_next.rsp.bresp = CWGSD_RESP_OKAY;
         unique case (state_reg.aw_addr)
            CWGSD_ADDR_MAIN:
               state_next.main_r = cwgsd_merge(state_reg.main_r, wb, CWGSD_MASK_MAIN, lane0);
            CWGSD_ADDR_OVR_SRC:
               state_next.ovr_r = cwgsd_merge(state_reg.ovr_r, wb, CWGSD_MASK_OVR_SRC, lane0);
            CWGSD_ADDR_SHDN: begin
               if (lane0) begin
                  state_next.shdn_r = wb & CWGSD_MASK_SHDN;
                  sw_sd = wb[CWGSD_BIT_ASE];
                  // writing one forces shutdown; clear only when inputs low
                  state_next.shdn_r[CWGSD_BIT_ASE] = wb[CWGSD_BIT_ASE]
                     | (state_reg.shdn_r[CWGSD_BIT_ASE] & ~clr_ok);
               end
            end
            CWGSD_ADDR_DB_RISE:
               state_next.dbr_r = cwgsd_merge(state_reg.dbr_r, wb, CWGSD_MASK_DB, lane0);
            CWGSD_ADDR_DB_FALL:
               state_next.dbf_r = cwgsd_merge(state_reg.dbf_r, wb, CWGSD_MASK_DB, lane0);
            default:
               state_next.rsp.bresp = CWGSD_RESP_SLVERR;
         endcase
      end
      if (state_reg.rsp.bvalid && axi_req.bready) begin
         state_next.rsp.bvalid = 1'b0;
      end

      // hardware shutdown sets status, and the set wins over any clear
      if (sd_active) begin
         state_next.shdn_r[CWGSD_BIT_ASE] = 1'b1;
      end
      // auto restart clears status once sources are low
      if (state_next.shdn_r[CWGSD_BIT_ARSEN] && clr_ok) begin
         state_next.shdn_r[CWGSD_BIT_ASE] = 1'b0;
      end

      // AXI4-Lite read
      if (state_reg.rsp.rvalid && axi_req.rready) begin
         state_next.rsp.rvalid = 1'b0;
      end
      state_next.rsp.arready = ~state_next.rsp.rvalid;
      if (axi_req.arvalid && axi_rsp.arready) begin
         state_next.rsp.arready = 1'b0;
         state_next.rsp.rvalid = 1'b1;
         state_next.rsp.rresp = CWGSD_RESP_OKAY;
         state_next.rsp.rdata = 32'h0000_0000;
         unique case (axi_req.araddr)
            CWGSD_ADDR_MAIN:    state_next.rsp.rdata[7:0] = state_reg.main_r;
            CWGSD_ADDR_OVR_SRC: state_next.rsp.rdata[7:0] = state_reg.ovr_r;
            CWGSD_ADDR_SHDN:    state_next.rsp.rdata[7:0] = state_reg.shdn_r;
            CWGSD_ADDR_DB_RISE: state_next.rsp.rdata[7:0] = state_reg.dbr_r;
            CWGSD_ADDR_DB_FALL: state_next.rsp.rdata[7:0] = state_reg.dbf_r;
            default:            state_next.rsp.rresp = CWGSD_RESP_SLVERR;
         endcase
      end

      // Dead-band sequencer
      if (!en) begin
         state_next.st = CWGSD_ST_SHUT;
         state_next.a_raw = 1'b0;
         state_next.b_raw = 1'b0;
         state_next.cnt = '0;
      end else if (state_next.shdn_r[CWGSD_BIT_ASE] || sw_sd) begin
         // a written one shuts down even if auto restart clears it at once
         // Inactive-level override: both raw levels cleared, drives kept, A and B fall in the same cycle with no dead band
         state_next.st = CWGSD_ST_SHUT;
         state_next.a_raw = 1'b0;
         state_next.b_raw = 1'b0;
      end else begin
         unique case (state_reg.st)
            // override held until the first rising edge
            CWGSD_ST_SHUT: begin
               if (rise) begin
                  state_next.st = CWGSD_ST_RDB;
                  state_next.cnt = '0;
               end
            end
            CWGSD_ST_RDB: begin
               // B off now, A on after rising count
               state_next.b_raw = 1'b0;
               if (fall) begin
                  state_next.st = CWGSD_ST_FDB;
                  state_next.cnt = '0;
               end else if (tick) begin
                  if (state_reg.cnt >= {1'b0, state_reg.dbr_r[DB_W-1:0]}) begin
                     state_next.a_raw = 1'b1;
                     state_next.st = CWGSD_ST_AON;
                  end else begin
                     state_next.cnt = state_reg.cnt + 1'b1;
                  end
               end
            end
            CWGSD_ST_AON: begin
               if (fall) begin
                  state_next.st = CWGSD_ST_FDB;
                  state_next.cnt = '0;
               end
            end
            CWGSD_ST_FDB: begin
               // A off now, B on after falling count; zero bypasses
               state_next.a_raw = 1'b0;
               if (rise) begin
                  state_next.st = CWGSD_ST_RDB;
                  state_next.cnt = '0;
               end else if (tick) begin
                  if (state_reg.cnt >= {1'b0, state_reg.dbf_r[DB_W-1:0]}) begin
                     state_next.b_raw = 1'b1;
                  end else begin
                     state_next.cnt = state_reg.cnt + 1'b1;
                  end
               end
            end
            default: state_next.st = CWGSD_ST_SHUT;
         endcase
         if (rise) begin
            state_next.b_raw = 1'b0;
         end
         if (fall) begin
            state_next.a_raw = 1'b0;
         end
         // a zero count hands over at once, no dead band
         if (rise && state_reg.dbr_r[DB_W-1:0] == '0) begin
            state_next.a_raw = 1'b1;
            state_next.st = CWGSD_ST_AON;
         end
         if (fall && state_reg.dbf_r[DB_W-1:0] == '0) begin
            state_next.b_raw = 1'b1;
         end
      end

      // pin drive from override, polarity and enable
      // overrides stand while idle, so a cleared status waits for a rising edge
      pa = cwgsd_pin(state_next.st == CWGSD_ST_SHUT,
                     state_reg.ovr_r[CWGSD_BIT_LVLA_HI:CWGSD_BIT_LVLA_LO],
                     state_reg.main_r[CWGSD_BIT_POLA], state_next.a_raw,
                     state_reg.main_r[CWGSD_BIT_OEA]);
      pb = cwgsd_pin(state_next.st == CWGSD_ST_SHUT,
                     state_reg.ovr_r[CWGSD_BIT_LVLB_HI:CWGSD_BIT_LVLB_LO],
                     state_reg.main_r[CWGSD_BIT_POLB], state_next.b_raw,
                     state_reg.main_r[CWGSD_BIT_OEB]);
      // disabled module releases and clears both pins
      if (!en) begin
         pa = 2'b01;
         pb = 2'b01;
      end
      state_next.pins = {pa, pb};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         state_reg.st <= CWGSD_ST_SHUT;
         state_reg.pins <= 4'b0101;
      end else begin
         state_reg <= state_next;
      end
   end

   assign axi_rsp = state_reg.rsp;
   assign pins    = state_reg.pins;
endmodule

// ===== sim/cwgsd_switch_model.sv
// Model of the external switch drivers on the two generator outputs
`timescale 1ns/1ps
module cwgsd_switch_model
   import cwgsd_pkg::*;
(
   // Generator pins
   input  wire cwgsd_pkg::cwgsd_pins_t pins,
   // Gate levels seen by the switches
   output logic                        a_gate,
   output logic                        b_gate
);
   // Gate inputs have pull-downs, so a released pin reads as switch off
   assign a_gate = !pins.a_oe_n && pins.a_out;
   assign b_gate = !pins.b_oe_n && pins.b_out;
endmodule

// ===== sim/cwgsd_top_sva.sv
// Port-level assertions for the waveform generator
`timescale 1ns/1ps
module cwgsd_top_sva
   import cwgsd_pkg::*;
#(
   parameter int DB_W = 6
) (
   // Clock and reset
   input wire logic                      aclk,
   input wire logic                      aresetn,
   // Register bus
   input wire cwgsd_pkg::cwgsd_axi_req_t axi_req,
   input wire cwgsd_pkg::cwgsd_axi_rsp_t axi_rsp,
   // Sources, fault and pins
   input wire logic                      comparator_out_unsynced,
   input wire logic                      pwm_channel1_out,
   input wire logic                      pwm_channel2_out,
   input wire logic                      pwm_channel3_out,
   input wire logic                      fault_input_n,
   input wire cwgsd_pkg::cwgsd_pins_t    pins
);
   logic [7:0] aw_reg, ar_reg, wd_reg, main_reg, main_d_reg, ovr_reg, shdn_reg;
   logic       ws_reg;
   logic [2:0] act_reg;
   logic       act_w;
   // Mirror of the control bits, one cycle behind the design's copy
   assign act_w = (shdn_reg[2] && comparator_out_unsynced) || (shdn_reg[1] && !fault_input_n);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_reg, ar_reg, wd_reg, main_reg, main_d_reg, ovr_reg, shdn_reg} <= '0;
         ws_reg <= 1'b0;
         act_reg <= 3'h0;
      end else begin
         if (axi_req.awvalid && axi_rsp.awready) aw_reg <= axi_req.awaddr;
         if (axi_req.arvalid && axi_rsp.arready) ar_reg <= axi_req.araddr;
         if (axi_req.wvalid && axi_rsp.wready) begin
            wd_reg <= axi_req.wdata[7:0];
            ws_reg <= axi_req.wstrb[0];
         end
         main_d_reg <= main_reg;
         if ($rose(axi_rsp.bvalid) && ws_reg && aw_reg == CWGSD_ADDR_MAIN) main_reg <= wd_reg;
         if ($rose(axi_rsp.bvalid) && ws_reg && aw_reg == CWGSD_ADDR_OVR_SRC) ovr_reg <= wd_reg;
         if ($rose(axi_rsp.bvalid) && ws_reg && aw_reg == CWGSD_ADDR_SHDN) shdn_reg <= wd_reg;
         // Any write restarts the count, so overrides are judged on settled setup
         act_reg <= (!act_w || axi_rsp.bvalid) ? 3'h0 : act_reg + {2'h0, act_reg != 3'h7};
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_disable_float: assert property (!main_reg[7] && !main_d_reg[7]
      |-> pins.a_oe_n && pins.b_oe_n) else $error("outputs driven while disabled");
   chk_gate_a_off: assert property (main_reg == main_d_reg && !main_reg[5]
      |-> pins.a_oe_n) else $error("output A on pin while its enable is clear");
   chk_ovr_a_low: assert property (act_reg == 3'h7 && main_reg[7] && main_reg[5]
      && ovr_reg[5:4] == 2'b10 |-> !pins.a_oe_n && !pins.a_out) else $error("A not low in shutdown");
   chk_ovr_b_high: assert property (act_reg == 3'h7 && main_reg[7] && main_reg[6]
      && ovr_reg[7:6] == 2'b11 |-> !pins.b_oe_n && pins.b_out) else $error("B not high in shutdown");
   chk_db_upper: assert property (axi_rsp.rvalid && (ar_reg == CWGSD_ADDR_DB_RISE
      || ar_reg == CWGSD_ADDR_DB_FALL) |-> axi_rsp.rdata[7:6] == 2'b00) else $error("db bits 7-6 set");
   chk_read_answer: assert property (axi_req.arvalid && axi_rsp.arready // Bus read
      |-> ##[1:2] axi_rsp.rvalid) else $error("read answer late");
   chk_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid // Bus
      && axi_rsp.wready |-> ##[1:3] axi_rsp.bvalid) else $error("write answer late");
   chk_unmapped_err: assert property ($rose(axi_rsp.bvalid) && !(aw_reg inside {8'h00, 8'h04, // Map
      8'h08, 8'h0C, 8'h10}) |-> axi_rsp.bresp == CWGSD_RESP_SLVERR) else $error("unmapped write ok");
endmodule
bind cwgsd_top cwgsd_top_sva #(.DB_W(DB_W)) chk_u (.aclk(aclk), .aresetn(aresetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .comparator_out_unsynced(comparator_out_unsynced),
   .pwm_channel1_out(pwm_channel1_out), .pwm_channel2_out(pwm_channel2_out),
   .pwm_channel3_out(pwm_channel3_out), .fault_input_n(fault_input_n), .pins(pins));

// ===== sim/cwgsd_top_tb.sv
// Self-checking testbench for the waveform generator
`timescale 1ns/1ps
module cwgsd_top_tb;
   import cwgsd_pkg::*;
   logic           aclk, aresetn, fault_n, a_gate, b_gate;
   logic [3:0]     srcs;
   cwgsd_axi_req_t req;
   cwgsd_axi_rsp_t rsp;
   cwgsd_pins_t    pins;
   int             mismatches, total_checks;
   cwgsd_top #(.DB_W(6)) dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .comparator_out_unsynced(srcs[0]), .pwm_channel1_out(srcs[1]), .pwm_channel2_out(srcs[2]),
      .pwm_channel3_out(srcs[3]), .fault_input_n(fault_n), .pins(pins));
   cwgsd_switch_model sw_u (.pins(pins), .a_gate(a_gate), .b_gate(b_gate));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic expire(input int n);
      if (n >= 400) begin
         mismatches++;
         $display("FAIL at %0t: wait ran out", $time);
         complete_run();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Each channel is held until its own handshake edge
   task automatic xfer(input bit wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.bready <= wr;
      req.arvalid <= !wr;
      req.rready <= !wr;
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= {24'h000000, d};
      do begin
         @(posedge aclk);
         n++;
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!(wr ? rsp.bvalid : rsp.rvalid) && n < 400);
      expire(n);
      q = rsp.rdata[7:0];
      r = wr ? rsp.bresp : rsp.rresp;
      req.bready <= 1'b0;
      req.rready <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic [1:0] r;
      xfer(1'b1, a, d, q, r);
      cmp({6'h00, r}, {6'h00, CWGSD_RESP_OKAY}, "write response");
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      logic [1:0] r;
      xfer(1'b0, a, 8'h00, q, r);
      cmp(q, exp, "read data");
   endtask
   function automatic logic [7:0] pv();
      return {4'h0, pins.a_oe_n, pins.a_out, pins.b_oe_n, pins.b_out};
   endfunction
   // Counts cycles from one switch turning off to the other turning on
   task automatic dbm(input bit rise, input int lo, input int hi);
      int n;
      n = 0;
      @(posedge aclk);
      srcs[1] <= rise;
      for (n = 0; (rise ? b_gate : a_gate) && n < 400; n++) @(posedge aclk);
      expire(n);
      for (n = 0; !(rise ? a_gate : b_gate) && n < 400; n++) @(posedge aclk);
      expire(n);
      cmp({7'h00, n >= lo && n <= hi}, 8'h01, "dead band length");
   endtask
   task automatic s_regs();
      logic [7:0] q;
      logic [1:0] r;
      cmp(pv(), 8'h0A, "pins after reset");
      for (int i = 0; i < 5; i++) rchk(8'(4 * i), CWGSD_RST_REG);
      xfer(1'b1, 8'h14, 8'hFF, q, r);
      cmp({6'h00, r}, {6'h00, CWGSD_RESP_SLVERR}, "unmapped write");
      xfer(1'b0, 8'h14, 8'h00, q, r);
      cmp({6'h00, r}, {6'h00, CWGSD_RESP_SLVERR}, "unmapped read");
      wreg(CWGSD_ADDR_DB_RISE, 8'hFF);
      rchk(CWGSD_ADDR_DB_RISE, 8'h3F);
      wreg(CWGSD_ADDR_DB_FALL, 8'hC2);
      rchk(CWGSD_ADDR_DB_FALL, 8'h02);
   endtask
   task automatic s_start();
      wreg(CWGSD_ADDR_MAIN, 8'h00);
      wreg(CWGSD_ADDR_DB_RISE, 8'h03);
      wreg(CWGSD_ADDR_SHDN, 8'h80);
      wreg(CWGSD_ADDR_OVR_SRC, 8'hB2);
      wreg(CWGSD_ADDR_MAIN, 8'h60);
      wreg(CWGSD_ADDR_MAIN, 8'hE0);
      cyc(8);
      cmp(pv(), 8'h04, "software shutdown levels");
      wreg(CWGSD_ADDR_SHDN, 8'h00);
      cyc(10);
      cmp(pv(), 8'h04, "override held to edge");
      srcs[1] <= 1'b1;
      cyc(12);
      dbm(1'b0, 2, 3);
      dbm(1'b1, 3, 4);
      wreg(CWGSD_ADDR_DB_FALL, 8'h00);
      dbm(1'b0, 0, 0);
      wreg(CWGSD_ADDR_MAIN, 8'hE1);
      dbm(1'b1, 18, 30);
      wreg(CWGSD_ADDR_MAIN, 8'hE8);
      cyc(8);
      cmp(pv(), 8'h00, "A inverted");
      wreg(CWGSD_ADDR_MAIN, 8'hF0);
      cyc(8);
      cmp(pv(), 8'h05, "B inverted");
      wreg(CWGSD_ADDR_MAIN, 8'hE0);
   endtask
   task automatic s_shut();
      wreg(CWGSD_ADDR_OVR_SRC, 8'hE2);
      wreg(CWGSD_ADDR_SHDN, 8'h04);
      srcs[0] <= 1'b1;
      cyc(8);
      cmp(pv(), 8'h01, "comparator shutdown");
      rchk(CWGSD_ADDR_SHDN, 8'h84);
      wreg(CWGSD_ADDR_SHDN, 8'h04);
      rchk(CWGSD_ADDR_SHDN, 8'h84);
      srcs[0] <= 1'b0;
      cyc(6);
      wreg(CWGSD_ADDR_SHDN, 8'h04);
      rchk(CWGSD_ADDR_SHDN, 8'h04);
      cyc(8);
      cmp(pv(), 8'h01, "override after clear");
      srcs[1] <= 1'b0;
      cyc(8);
      srcs[1] <= 1'b1;
      cyc(14);
      cmp(pv(), 8'h04, "resumed on rising edge");
      wreg(CWGSD_ADDR_OVR_SRC, 8'h62);
      wreg(CWGSD_ADDR_SHDN, 8'h42);
      fault_n <= 1'b0;
      cyc(8);
      cmp(pv() & 8'h0E, 8'h02, "fault levels");
      rchk(CWGSD_ADDR_SHDN, 8'hC2);
      fault_n <= 1'b1;
      cyc(8);
      rchk(CWGSD_ADDR_SHDN, 8'h42);
      wreg(CWGSD_ADDR_SHDN, 8'hC0);
      rchk(CWGSD_ADDR_SHDN, 8'h40);
   endtask
   task automatic s_src();
      logic [2:0] code [4] = '{3'h3, 3'h4, 3'h0, 3'h1};
      logic [3:0] hot [4] = '{4'h4, 4'h8, 4'h1, 4'h2};
      wreg(CWGSD_ADDR_SHDN, 8'h00);
      for (int i = 0; i < 4; i++) begin
         srcs <= 4'h0;
         wreg(CWGSD_ADDR_OVR_SRC, {5'h00, code[i]});
         cyc(10);
         srcs <= hot[i];
         cyc(14);
         cmp({7'h00, pins.a_out}, {7'h00, i != 3}, "source select");
      end
      wreg(CWGSD_ADDR_MAIN, 8'hC0);
      cyc(6);
      cmp({7'h00, pins.a_oe_n}, 8'h01, "A off pin");
      wreg(CWGSD_ADDR_MAIN, 8'h60);
      cyc(6);
      cmp({6'h00, pins.a_oe_n, pins.b_oe_n}, 8'h03, "disabled pins");
   endtask
   initial begin
      aresetn = 1'b0;
      req = '0;
      req.wstrb = 4'hF;
      srcs = 4'h0;
      fault_n = 1'b1;
      mismatches = 0;
      total_checks = 0;
      cyc(20);
      aresetn <= 1'b1;
      s_regs();
      s_start();
      s_shut();
      s_src();
      complete_run();
   end
endmodule
